//--- weld_stepper_cfg.svh
`ifndef WELD_STEPPER_CFG_SVH
`define WELD_STEPPER_CFG_SVH

// Stepper enable codes
`define MODE_OFF         2'h0
`define MODE_MULTI       2'h1
`define MODE_SINGLE      2'h2

// Schedule map
`define SCHED_COUNT      100
`define STEPS_PER        10
`define STEPPER_COUNT    10
`define LAST_SCHED       7'h63
`define SECOND_STEPPER   4'h2
`define FOURTH_STEPPER   4'h4
`define SECOND_FIRST     7'h14
`define FOURTH_FIRST     7'h28

// Count field: four BCD digits, thousands in the top nibble
`define DIGIT_ONES       0
`define DIGIT_TENS       4
`define DIGIT_HUNDREDS   8
`define DIGIT_THOUSANDS  12
`define COUNT_RESET      16'h0000

// Panel gesture timing
`define CLOCK_KHZ        10000
`define LONG_PRESS_MS    500

`endif

//--- weld_stepper_pkg.sv
package weld_stepper_pkg;

	typedef logic [15:0] bcd_count_t;
	typedef logic [6:0]  sched_t;

	typedef enum logic [1:0]
	{
		STEP_OFF    = 2'b00,
		STEP_MULTI  = 2'b01,
		STEP_SINGLE = 2'b10
	} step_mode_t;

	typedef enum logic
	{
		SEQ_IDLE = 1'b0,
		SEQ_RUN  = 1'b1
	} seq_state_t;

	typedef struct packed
	{
		logic enter;
		logic left_data;
		logic right_data;
		logic right_sched;
	} panel_t;

	typedef struct packed
	{
		logic weld_time_set;
		logic current_set;
		logic weld_selected;
	} weld_qual_t;

	typedef struct packed
	{
		logic long_press;
		logic short_press;
	} gesture_t;

endpackage

//--- press_gesture.sv
`timescale 1ns/1ps
`include "weld_stepper_cfg.svh"

module press_gesture
	import weld_stepper_pkg::*;
#(
	parameter int LONG_CYCLES = `LONG_PRESS_MS * `CLOCK_KHZ
)
(
	// Clock and reset
	input  wire logic     clock,
	input  wire logic     rst_n,
	// Button level and gate
	input  wire logic     button,
	input  wire logic     allow,
	// Classified press
	output gesture_t      gesture
);

	logic [31:0] held;
	logic [31:0] next_held;
	logic        fired;
	logic        next_fired;
	gesture_t    next_gesture;

	// A long press fires once at the threshold; release after it gives nothing
	always_comb
	begin
		next_held    = held;
		next_fired   = fired;
		next_gesture = '0;
		if (button)
		begin
			if (held < 32'(LONG_CYCLES))
				next_held = held + 32'h1;
			if (next_held == 32'(LONG_CYCLES) && !fired)
			begin
				next_fired              = 1'b1;
				next_gesture.long_press = allow;
			end
		end
		else
		begin
			next_gesture.short_press = allow && held != 32'h0 && !fired;
			next_held                = 32'h0;
			next_fired               = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			held    <= 32'h0;
			fired   <= 1'b0;
			gesture <= '0;
		end
		else
		begin
			held    <= next_held;
			fired   <= next_fired;
			gesture <= next_gesture;
		end
	end

endmodule

//--- weld_stepper_counter.sv
// Functional notes
// - Multi mode: stepper n owns schedules n0 to n9 as its steps.
// - Each schedule holds a decimal weld count from 0000 to 9999.
// - Mode code 00 disables, 01 multi steppers, 02 one single counter.
// - Single mode keeps one counter spanning schedules 00 to 99.
// - Last step limited to own ten schedules in multi, up to 99 single.
// - Last step is the start step; reloaded on stepper reset.
// - Last count 0000-9999 is the start count; reloaded on stepper reset.
// - Enter held plus both data buttons resets the displayed schedule's stepper.
// - After the last step completes welding halts and end-of-stepper shows.
// - Steppers reset one at a time, only in program mode.
// - Long/short left press steps thousands/hundreds; right steps tens/ones.
// - Enter plus right schedule button copies the schedule to the next one.
// - Count decrements only for a real weld: time, current and weld mode.
// - Optional alarm output once the final step has finished.
// - Dedicated inputs start steppers two and four in multi, schedules 20 and 40 uncounted in single; general starts displayed.
// - Single mode: zero count after the last step means end of stepper.
`timescale 1ns/1ps
`include "weld_stepper_cfg.svh"

module weld_stepper_counter
	import weld_stepper_pkg::*;
#(
	parameter int LONG_PRESS_CYCLES = `LONG_PRESS_MS * `CLOCK_KHZ
)
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Configuration
	input  wire step_mode_t stepper_mode,
	input  wire logic       program_mode,
	input  wire logic       alarm_enable,
	input  wire weld_qual_t weld_qual,
	// Front panel
	input  wire sched_t     displayed_sched,
	input  wire panel_t     panel,
	input  wire logic       last_step_write,
	input  wire sched_t     last_step_value,
	input  wire logic       last_count_write,
	input  wire bcd_count_t last_count_value,
	// Initiation and sequence events
	input  wire logic       general_initiate_input,
	input  wire logic       second_stepper_initiate_input,
	input  wire logic       fourth_stepper_initiate_input,
	input  wire logic       weld_made,
	input  wire logic       seq_done,
	// Results
	output sched_t          active_sched,
	output logic            seq_start,
	output logic            copy_done,
	output logic            end_of_stepper,
	output logic            alarm_out,
	output bcd_count_t      shown_count
);

	function automatic logic [3:0] stepper_of(input sched_t s, input step_mode_t m);
		return (m == STEP_SINGLE) ? 4'h0 : 4'(s / 7'd10);
	endfunction

	function automatic sched_t first_of(input logic [3:0] idx, input step_mode_t m);
		return (m == STEP_SINGLE) ? 7'h00 : 7'(idx * 4'd10);
	endfunction

	function automatic bcd_count_t bcd_dec(input bcd_count_t c);
		bcd_count_t r;
		logic       borrow;
		r      = c;
		borrow = 1'b1;
		for (int d = 0; d < 4; d++)
		begin
			if (borrow)
			begin
				borrow = (c[d*4 +: 4] == 4'h0);
				r[d*4 +: 4] = borrow ? 4'h9 : c[d*4 +: 4] - 4'h1;
			end
		end
		return (c == 16'h0) ? 16'h0 : r;
	endfunction

	function automatic bcd_count_t bump_digit(input bcd_count_t c, input int pos);
		bcd_count_t r;
		r = c;
		r[pos +: 4] = (c[pos +: 4] >= 4'h9) ? 4'h0 : c[pos +: 4] + 4'h1;
		return r;
	endfunction

	bcd_count_t weld_count [`SCHED_COUNT];
	sched_t     step_no [`STEPPER_COUNT];
	bcd_count_t remain [`STEPPER_COUNT];
	logic       ended [`STEPPER_COUNT];

	gesture_t   left_g;
	gesture_t   right_g;
	panel_t     panel_q;
	seq_state_t state;
	seq_state_t next_state;
	logic [3:0] run_idx;
	logic [3:0] next_run_idx;
	logic       counting;
	logic       next_counting;

	logic       cnt_we;
	sched_t     cnt_addr;
	bcd_count_t cnt_data;
	logic       st_we;
	logic [3:0] st_idx;
	sched_t     st_step;
	bcd_count_t st_rem;
	logic       st_end;

	sched_t     next_active_sched;
	logic       next_seq_start;
	logic       next_copy_done;

	logic [3:0] disp_idx;
	logic       gesture_ok;
	logic       reset_chord;
	logic       copy_chord;
	bcd_count_t dec_rem;
	sched_t     adv_step;
	logic       adv_past;
	logic       multi_ok;
	logic [3:0] start_idx;
	logic       start_req;

	assign disp_idx   = stepper_of(displayed_sched, stepper_mode);
	assign gesture_ok = program_mode && !panel.enter;

	press_gesture #(.LONG_CYCLES(LONG_PRESS_CYCLES)) left_press
	(
		.clock   (clock),
		.rst_n   (rst_n),
		.button  (panel.left_data),
		.allow   (gesture_ok),
		.gesture (left_g)
	);

	press_gesture #(.LONG_CYCLES(LONG_PRESS_CYCLES)) right_press
	(
		.clock   (clock),
		.rst_n   (rst_n),
		.button  (panel.right_data),
		.allow   (gesture_ok),
		.gesture (right_g)
	);

	// Chords act on the press edge so a held chord does one action
	assign reset_chord = program_mode && panel.enter && panel.left_data && panel.right_data
		&& !(panel_q.enter && panel_q.left_data && panel_q.right_data);
	assign copy_chord  = program_mode && panel.enter && panel.right_sched && !panel_q.right_sched
		&& displayed_sched < `LAST_SCHED;

	assign dec_rem  = bcd_dec(remain[run_idx]);
	assign adv_step = step_no[run_idx] + 7'h1;
	assign adv_past = (stepper_mode == STEP_SINGLE) ? (adv_step > `LAST_SCHED)
		: (adv_step % 7'd10 == 7'h0);
	assign multi_ok = last_step_value / 7'd10 == 7'(disp_idx);

	// Schedule weld counts: digit entry and copy
	always_comb
	begin
		cnt_we   = 1'b0;
		cnt_addr = displayed_sched;
		cnt_data = weld_count[displayed_sched];
		if (copy_chord)
		begin
			cnt_we   = 1'b1;
			cnt_addr = displayed_sched + 7'h1;
		end
		else if (left_g.long_press)
		begin
			cnt_we   = 1'b1;
			cnt_data = bump_digit(cnt_data, `DIGIT_THOUSANDS);
		end
		else if (left_g.short_press)
		begin
			cnt_we   = 1'b1;
			cnt_data = bump_digit(cnt_data, `DIGIT_HUNDREDS);
		end
		else if (right_g.long_press)
		begin
			cnt_we   = 1'b1;
			cnt_data = bump_digit(cnt_data, `DIGIT_TENS);
		end
		else if (right_g.short_press)
		begin
			cnt_we   = 1'b1;
			cnt_data = bump_digit(cnt_data, `DIGIT_ONES);
		end
	end

	// Per-stepper state: one update per cycle, welding before panel actions
	always_comb
	begin
		st_we   = 1'b0;
		st_idx  = disp_idx;
		st_step = step_no[disp_idx];
		st_rem  = remain[disp_idx];
		st_end  = ended[disp_idx];
		if (state == SEQ_RUN && counting && weld_made
			&& weld_qual.weld_time_set && weld_qual.current_set && weld_qual.weld_selected)
		begin
			st_we   = 1'b1;
			st_idx  = run_idx;
			st_step = step_no[run_idx];
			st_rem  = dec_rem;
			st_end  = 1'b0;
			if (dec_rem == 16'h0)
			begin
				if (adv_past || weld_count[adv_step] == 16'h0)
					st_end = 1'b1;
				else
				begin
					st_step = adv_step;
					st_rem  = weld_count[adv_step];
				end
			end
		end
		else if (reset_chord && stepper_mode != STEP_OFF)
		begin
			st_we   = 1'b1;
			st_step = first_of(disp_idx, stepper_mode);
			st_rem  = weld_count[st_step];
			st_end  = 1'b0;
		end
		else if (program_mode && last_step_write)
		begin
			st_we   = (stepper_mode == STEP_SINGLE) ? last_step_value <= `LAST_SCHED
				: multi_ok;
			st_step = last_step_value;
			st_end  = 1'b0;
		end
		else if (program_mode && last_count_write)
		begin
			st_we  = 1'b1;
			st_rem = last_count_value;
			st_end = 1'b0;
		end
	end

	// Initiation; a dedicated input wins over the general one in multi mode; in single mode the general one wins
	always_comb
	begin
		start_req = 1'b1;
		start_idx = disp_idx;
		if (second_stepper_initiate_input)
			start_idx = (stepper_mode == STEP_MULTI) ? `SECOND_STEPPER : 4'h0;
		else if (fourth_stepper_initiate_input)
			start_idx = (stepper_mode == STEP_MULTI) ? `FOURTH_STEPPER : 4'h0;
		else if (!general_initiate_input)
			start_req = 1'b0;
	end

	always_comb
	begin
		next_state        = state;
		next_run_idx      = run_idx;
		next_counting     = counting;
		next_active_sched = active_sched;
		next_seq_start    = 1'b0;
		next_copy_done    = copy_chord;
		unique case (state)
			SEQ_IDLE:
			begin
				if (start_req && !program_mode)
				begin
					if (stepper_mode == STEP_OFF)
					begin
						next_state        = SEQ_RUN;
						next_seq_start    = 1'b1;
						next_counting     = 1'b0;
						next_active_sched = displayed_sched;
					end
					else if (!ended[start_idx])
					begin
						next_state        = SEQ_RUN;
						next_seq_start    = 1'b1;
						next_run_idx      = start_idx;
						next_counting     = 1'b1;
						next_active_sched = step_no[start_idx];
						if (stepper_mode == STEP_SINGLE && !general_initiate_input)
						begin
							// Single counter counts only general starts
							next_counting     = 1'b0;
							next_active_sched = second_stepper_initiate_input
								? `SECOND_FIRST : `FOURTH_FIRST;
						end
					end
				end
			end
			SEQ_RUN:
			begin
				if (st_we && st_idx == run_idx && counting)
					next_active_sched = st_step;
				if (seq_done || (st_we && st_end && st_idx == run_idx))
					next_state = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state          <= SEQ_IDLE;
			run_idx        <= 4'h0;
			counting       <= 1'b0;
			active_sched   <= 7'h00;
			seq_start      <= 1'b0;
			copy_done      <= 1'b0;
			end_of_stepper <= 1'b0;
			alarm_out      <= 1'b0;
			shown_count    <= `COUNT_RESET;
			panel_q        <= '0;
			for (int i = 0; i < `SCHED_COUNT; i++)
				weld_count[i] <= `COUNT_RESET;
			for (int i = 0; i < `STEPPER_COUNT; i++)
			begin
				step_no[i] <= 7'(i * `STEPS_PER);
				remain[i]  <= `COUNT_RESET;
				ended[i]   <= 1'b0;
			end
		end
		else
		begin
			state          <= next_state;
			run_idx        <= next_run_idx;
			counting       <= next_counting;
			active_sched   <= next_active_sched;
			seq_start      <= next_seq_start;
			copy_done      <= next_copy_done;
			end_of_stepper <= ended[disp_idx];
			alarm_out      <= alarm_enable && ended[disp_idx];
			shown_count    <= remain[disp_idx];
			panel_q        <= panel;
			if (cnt_we)
				weld_count[cnt_addr] <= cnt_data;
			if (st_we)
			begin
				step_no[st_idx] <= st_step;
				remain[st_idx]  <= st_rem;
				ended[st_idx]   <= st_end;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	logic real_weld;
	assign real_weld = state == SEQ_RUN && counting && weld_made && weld_qual.weld_time_set
		&& weld_qual.current_set && weld_qual.weld_selected;

	no_fake_count_a: assert property (
		weld_made && !weld_qual.weld_selected && !reset_chord && !last_count_write
		|=> remain[$past(run_idx)] == $past(remain[run_idx]))
		else $error("count moved without a real weld");
	count_dec_a: assert property (
		real_weld && remain[run_idx] > 16'h1 && !adv_past
		|=> remain[$past(run_idx)] == bcd_dec($past(remain[run_idx])))
		else $error("real weld did not decrement");
	step_adv_a: assert property (
		real_weld && remain[run_idx] == 16'h1 && !adv_past && weld_count[adv_step] != 16'h0
		|=> step_no[$past(run_idx)] == $past(adv_step)
		&& remain[$past(run_idx)] == $past(weld_count[adv_step]))
		else $error("step did not advance");
	end_halt_a: assert property (
		real_weld && remain[run_idx] == 16'h1 && (adv_past || weld_count[adv_step] == 16'h0)
		|=> ended[$past(run_idx)] && state == SEQ_IDLE)
		else $error("last step did not halt");
	ended_refused_a: assert property (
		state == SEQ_IDLE && stepper_mode != STEP_OFF && start_req && ended[start_idx]
		|=> !seq_start)
		else $error("ended stepper started");
	reset_program_a: assert property (
		!program_mode && !real_weld && !last_step_write && !last_count_write
		|=> step_no[$past(disp_idx)] == $past(step_no[disp_idx]))
		else $error("stepper changed outside program mode");
	reset_reload_a: assert property (
		reset_chord && stepper_mode == STEP_MULTI && !real_weld
		|=> step_no[$past(disp_idx)] == 7'($past(disp_idx) * 4'd10) && !ended[$past(disp_idx)])
		else $error("stepper reset did not reload");
	second_start_a: assert property (
		state == SEQ_IDLE && !program_mode && stepper_mode == STEP_MULTI
		&& second_stepper_initiate_input && !ended[2]
		|=> seq_start && run_idx == 4'h2 ##1 !seq_start)
		else $error("second stepper input misrouted");
	copy_next_a: assert property (
		copy_chord |=> weld_count[$past(displayed_sched) + 7'h1] == $past(weld_count[displayed_sched])
		&& copy_done)
		else $error("schedule copy failed");
	alarm_end_a: assert property (
		alarm_out |-> $past(ended[disp_idx]) && $past(alarm_enable))
		else $error("alarm without end of stepper");

	start_c: cover property (seq_start && counting);
	advance_c: cover property (real_weld && remain[run_idx] == 16'h1 ##1 state == SEQ_RUN);
	end_c: cover property (end_of_stepper ##[1:20] reset_chord);

endmodule

//--- front_panel_model.sv
`timescale 1ns/1ps

module front_panel_model
	import weld_stepper_pkg::*;
(
	// Clock
	input  wire logic clock,
	// Buttons and initiation switches
	output panel_t    panel,
	output logic      general_initiate_input,
	output logic      second_stepper_initiate_input,
	output logic      fourth_stepper_initiate_input
);
	initial
	begin
		panel = '0;
		general_initiate_input = 1'h0;
		second_stepper_initiate_input = 1'h0;
		fourth_stepper_initiate_input = 1'h0;
	end

	// Hold one data button; a long hold must outlast the gesture threshold
	task automatic press(input bit right, input int cycles);
		@(posedge clock);
		if (right)
			panel.right_data <= 1'h1;
		else
			panel.left_data <= 1'h1;
		repeat (cycles) @(posedge clock);
		panel.right_data <= 1'h0;
		panel.left_data <= 1'h0;
		repeat (3) @(posedge clock);
	endtask

	// Data buttons drop before enter so no stray digit press is seen
	task automatic reset_chord;
		@(posedge clock);
		panel.enter <= 1'h1;
		@(posedge clock);
		panel.left_data <= 1'h1;
		panel.right_data <= 1'h1;
		repeat (2) @(posedge clock);
		panel.left_data <= 1'h0;
		panel.right_data <= 1'h0;
		@(posedge clock);
		panel.enter <= 1'h0;
		repeat (3) @(posedge clock);
	endtask

	task automatic copy_chord;
		@(posedge clock);
		panel.enter <= 1'h1;
		@(posedge clock);
		panel.right_sched <= 1'h1;
		@(posedge clock);
		panel.right_sched <= 1'h0;
		@(posedge clock);
		panel.enter <= 1'h0;
		repeat (2) @(posedge clock);
	endtask

	// 0 general, 1 second stepper, 2 fourth stepper; held three cycles
	task automatic initiate(input int which);
		@(posedge clock);
		general_initiate_input <= (which == 0);
		second_stepper_initiate_input <= (which == 1);
		fourth_stepper_initiate_input <= (which == 2);
		repeat (3) @(posedge clock);
		general_initiate_input <= 1'h0;
		second_stepper_initiate_input <= 1'h0;
		fourth_stepper_initiate_input <= 1'h0;
		repeat (2) @(posedge clock);
	endtask
endmodule

//--- test_weld_stepper_counter.sv
`timescale 1ns/1ps

module test_weld_stepper_counter
	import weld_stepper_pkg::*;
;
	logic       clock;
	logic       rst_n;
	step_mode_t stepper_mode;
	logic       program_mode;
	logic       alarm_enable;
	weld_qual_t weld_qual;
	sched_t     displayed_sched;
	panel_t     panel;
	logic       last_step_write;
	sched_t     last_step_value;
	logic       last_count_write;
	bcd_count_t last_count_value;
	logic       gen_init;
	logic       second_init;
	logic       fourth_init;
	logic       weld_made;
	logic       seq_done;
	sched_t     active_sched;
	logic       seq_start;
	logic       copy_done;
	logic       end_of_stepper;
	logic       alarm_out;
	bcd_count_t shown_count;
	int         fail_count;
	int         cmp_count;
	int         starts;
	int         copies;

	// Short threshold keeps long presses to a handful of cycles
	weld_stepper_counter #(.LONG_PRESS_CYCLES(8)) i_weld_stepper_counter (
		.clock(clock), .rst_n(rst_n), .stepper_mode(stepper_mode),
		.program_mode(program_mode), .alarm_enable(alarm_enable), .weld_qual(weld_qual),
		.displayed_sched(displayed_sched), .panel(panel), .last_step_write(last_step_write),
		.last_step_value(last_step_value), .last_count_write(last_count_write),
		.last_count_value(last_count_value), .general_initiate_input(gen_init),
		.second_stepper_initiate_input(second_init),
		.fourth_stepper_initiate_input(fourth_init), .weld_made(weld_made),
		.seq_done(seq_done), .active_sched(active_sched), .seq_start(seq_start),
		.copy_done(copy_done), .end_of_stepper(end_of_stepper), .alarm_out(alarm_out),
		.shown_count(shown_count));

	front_panel_model i_front_panel_model (
		.clock(clock), .panel(panel), .general_initiate_input(gen_init),
		.second_stepper_initiate_input(second_init),
		.fourth_stepper_initiate_input(fourth_init));

	always #50 clock = ~clock;

	// Counting pulses at mid-cycle also proves each one lasts a single cycle
	always @(negedge clock)
	begin
		if (seq_start === 1'h1)
			starts++;
		if (copy_done === 1'h1)
			copies++;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic set_prog(input logic p);
		@(posedge clock);
		program_mode <= p;
	endtask

	task automatic weld(input int n);
		repeat (n)
		begin
			@(posedge clock);
			weld_made <= 1'h1;
			@(posedge clock);
			weld_made <= 1'h0;
			tick(3);
		end
	endtask

	task automatic seq_over;
		@(posedge clock);
		seq_done <= 1'h1;
		@(posedge clock);
		seq_done <= 1'h0;
		tick(2);
	endtask

	task automatic write_step(input sched_t v);
		@(posedge clock);
		last_step_value <= v;
		last_step_write <= 1'h1;
		@(posedge clock);
		last_step_write <= 1'h0;
		tick(2);
	endtask

	task automatic write_count(input bcd_count_t v);
		@(posedge clock);
		last_count_value <= v;
		last_count_write <= 1'h1;
		@(posedge clock);
		last_count_write <= 1'h0;
		tick(2);
	endtask

	task automatic start(input int which, input sched_t exp);
		int s;
		s = starts;
		i_front_panel_model.initiate(which);
		check(16'(starts - s), 16'h0001);
		check({9'h0, active_sched}, {9'h0, exp});
	endtask

	task automatic test_reset;
		@(negedge clock);
		check(shown_count, 16'h0000);
		check({12'h0, end_of_stepper, alarm_out, seq_start, copy_done}, 16'h0000);
		$display("test_reset done");
	endtask

	task automatic test_entry;
		set_prog(1'h1);
		displayed_sched <= 7'h01;
		i_front_panel_model.press(0, 10);
		i_front_panel_model.press(0, 2);
		i_front_panel_model.press(1, 10);
		i_front_panel_model.press(1, 2);
		i_front_panel_model.press(1, 2);
		i_front_panel_model.copy_chord();
		check(16'(copies), 16'h0001);
		displayed_sched <= 7'h00;
		i_front_panel_model.reset_chord();
		write_count(16'h0002);
		check(shown_count, 16'h0002);
		set_prog(1'h0);
		weld_qual <= 3'h6;
		start(0, 7'h00);
		weld(1);
		check(shown_count, 16'h0002);
		weld_qual <= 3'h7;
		weld(2);
		check(shown_count, 16'h1112);
		check({9'h0, active_sched}, 16'h0001);
		seq_over();
		$display("test_entry done");
	endtask

	task automatic test_end;
		int s;
		set_prog(1'h1);
		alarm_enable <= 1'h1;
		write_step(7'h09);
		write_count(16'h0001);
		set_prog(1'h0);
		start(0, 7'h09);
		weld(1);
		check({14'h0, end_of_stepper, alarm_out}, 16'h0003);
		i_front_panel_model.reset_chord();
		check({15'h0, end_of_stepper}, 16'h0001);
		s = starts;
		i_front_panel_model.initiate(0);
		check(16'(starts - s), 16'h0000);
		set_prog(1'h1);
		i_front_panel_model.reset_chord();
		check({14'h0, end_of_stepper, alarm_out}, 16'h0000);
		check(shown_count, 16'h0000);
		$display("test_end done");
	endtask

	task automatic test_dedicated;
		set_prog(1'h0);
		start(1, 7'h14);
		seq_over();
		start(2, 7'h28);
		seq_over();
		displayed_sched <= 7'h37;
		start(0, 7'h32);
		seq_over();
		$display("test_dedicated done");
	endtask

	task automatic test_off;
		@(posedge clock);
		stepper_mode <= STEP_OFF;
		displayed_sched <= 7'h2a;
		start(0, 7'h2a);
		seq_over();
		$display("test_off done");
	endtask

	task automatic test_single;
		@(posedge clock);
		stepper_mode <= STEP_SINGLE;
		displayed_sched <= 7'h00;
		set_prog(1'h1);
		i_front_panel_model.reset_chord();
		write_step(7'h05);
		write_count(16'h0001);
		set_prog(1'h0);
		start(1, 7'h14);
		seq_over();
		start(0, 7'h05);
		weld(1);
		check({15'h0, end_of_stepper}, 16'h0001);
		$display("test_single done");
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		clock = 1'h0;
		rst_n = 1'h0;
		stepper_mode = STEP_MULTI;
		program_mode = 1'h0;
		alarm_enable = 1'h0;
		weld_qual = 3'h7;
		displayed_sched = 7'h00;
		last_step_write = 1'h0;
		last_step_value = 7'h00;
		last_count_write = 1'h0;
		last_count_value = 16'h0000;
		weld_made = 1'h0;
		seq_done = 1'h0;
		fail_count = 0;
		cmp_count = 0;
		starts = 0;
		copies = 0;
		tick(8);
		rst_n <= 1'h1;
		tick(2);
		test_reset();
		test_entry();
		test_end();
		test_dedicated();
		test_off();
		test_single();
		tally_and_finish();
	end
endmodule
